// ==== async_sram_module_32bit_tb.sv ====
`timescale 1ns/100ps
`default_nettype none
module async_sram_module_32bit_tb;
  logic clock = 0, rst_b = 0, req_valid = 0, req_write = 0;
  logic [19:0] req_addr = 0, addr;
  logic [31:0] req_wdata = 0, d_out, d_in, m_q, rdata, r, ref_m [8];
  logic [3:0] req_lanes = 0, sel_n, dens, dens_p;
  logic req_ready, rsp_valid, we_n, oe_n, d_oe;
  int n_fail = 0, checks = 0, acc = 25, seed = 32'h4bfd_76fc;
  always #5 clock = ~clock;
  assign d_in = d_oe ? d_out : m_q;
  sram_ctrl u_sram_ctrl (.clock(clock), .rst_b(rst_b),
    .req_valid(req_valid), .req_ready(req_ready), .req_write(req_write),
    .req_addr(req_addr), .req_wdata(req_wdata), .req_lanes(req_lanes),
    .rsp_valid(rsp_valid), .rsp_rdata(rdata), .density_id(dens),
    .word_address_lines(addr), .byte_lane_select_n(sel_n),
    .write_strobe_n(we_n), .output_enable_n(oe_n),
    .bidir_data_lines_in(d_in), .bidir_data_lines_out(d_out),
    .bidir_data_lines_oe(d_oe), .density_id_pins(dens_p));
  sram_model u_sram_model (.addr(addr), .sel_n(sel_n), .we_n(we_n),
    .oe_n(oe_n), .din(d_in), .acc_ns(acc), .q(m_q), .dens(dens_p));
  function automatic logic [31:0] msk(input logic [3:0] l);
    for (int i = 0; i < 4; i++) msk[8*i+:8] = {8{l[i]}};
  endfunction
  task automatic chk(input string s, input logic [31:0] seen, exp);
    checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED %s exp %h seen %h", s, exp, seen);
    end
  endtask
  task automatic xfer(input logic w, input logic [2:0] k,
    input logic [3:0] l);
    int n;
    logic [31:0] d;
    logic [31:0] m;
    n = 0;
    d = $random(seed);
    m = msk(l);
    req_valid = 1;
    req_write = w;
    req_addr = (k == 3'h7) ? 20'hf_ffff : {k, 17'h0_0000};
    req_wdata = d;
    req_lanes = l;
    while (req_ready !== 1'b1 && n < 20)
    begin
      @(posedge clock);
      #1;
      n++;
    end
    @(posedge clock);
    #1;
    req_valid = 0;
    while (rsp_valid !== 1'b1 && n < 40)
    begin
      @(posedge clock);
      #1;
      n++;
    end
    chk("answer", 32'(n < 40), 32'h1);
    if (w)
      ref_m[k] = (ref_m[k] & ~m) | (d & m);
    else
      chk("read data", rdata & m, ref_m[k] & m);
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial
  begin
    #100000;
    n_fail++;
    end_of_test;
  end
  initial
  begin
    repeat (20) @(posedge clock);
    #1;
    rst_b = 1;
    repeat (4) @(posedge clock);
    #1;
    chk("density", {28'h0, dens}, 32'h0000_0005);
    $display("test density done");
    for (int k = 0; k < 8; k++) xfer(1, k[2:0], 4'hf);
    for (int k = 0; k < 8; k++) xfer(0, k[2:0], 4'hf);
    xfer(1, 3'h3, 4'h0);
    xfer(0, 3'h3, 4'hf);
    $display("test corner words done");
    for (int j = 0; j < 80; j++)
    begin
      r = $random(seed);
      if (j == 40) acc = 12;
      xfer(r[4], r[2:0], r[8:5]);
    end
    $display("test random lanes done");
    end_of_test;
  end
endmodule
`default_nettype wire

// ==== sram_ctrl.sv ====
// Operation
// - Address changes only while strobe deasserted.
// - Address valid before select and strobe low.
// - Host never drives bus during reads.
// - Address and select held before write end.
// - Write data held before strobe rises.
`timescale 1ns/100ps
`default_nettype none
`include "sram_ctrl_consts.svh"
module sram_ctrl #(
  parameter int ADDR_WIDTH = `ADDR_WIDTH,
  parameter int DATA_WIDTH = `DATA_WIDTH,
  parameter int LANES = `LANES
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_write,
  input wire logic [ADDR_WIDTH-1:0] req_addr,
  input wire logic [DATA_WIDTH-1:0] req_wdata,
  input wire logic [LANES-1:0] req_lanes,
  output logic rsp_valid,
  output logic [DATA_WIDTH-1:0] rsp_rdata,
  output logic [`DENSITY_WIDTH-1:0] density_id,
  output logic [ADDR_WIDTH-1:0] word_address_lines,
  output logic [LANES-1:0] byte_lane_select_n,
  output logic write_strobe_n,
  output logic output_enable_n,
  input wire logic [DATA_WIDTH-1:0] bidir_data_lines_in,
  output logic [DATA_WIDTH-1:0] bidir_data_lines_out,
  output logic bidir_data_lines_oe,
  input wire logic [`DENSITY_WIDTH-1:0] density_id_pins
);
  // Each lane select covers exactly one byte of the data word.
  if (DATA_WIDTH != LANES * 8 || ADDR_WIDTH < 1)
  begin
    $error("DATA_WIDTH must be eight bits per lane");
  end

  localparam int CW = 3;
  localparam logic [CW-1:0] RD_CYC = CW'(`READ_WAIT_CYC);
  localparam logic [CW-1:0] WR_CYC = CW'(`WRITE_WAIT_CYC);
  localparam logic [CW-1:0] FL_CYC = CW'(`FLOAT_WAIT_CYC);

  sram_ctrl_pkg::state_t state_ff, nxt_state_ff;
  logic [CW-1:0] cnt_ff, nxt_cnt_ff;
  logic req_ready_ff, nxt_req_ready_ff;
  logic rsp_valid_ff, nxt_rsp_valid_ff;
  logic [DATA_WIDTH-1:0] rdata_ff, nxt_rdata_ff;
  logic [ADDR_WIDTH-1:0] addr_ff, nxt_addr_ff;
  logic [LANES-1:0] sel_n_ff, nxt_sel_n_ff;
  logic [LANES-1:0] lanes_ff, nxt_lanes_ff;
  logic we_n_ff, nxt_we_n_ff;
  logic oe_n_ff, nxt_oe_n_ff;
  logic [DATA_WIDTH-1:0] wdata_ff, nxt_wdata_ff;
  logic drive_ff, nxt_drive_ff;
  logic [3*`DENSITY_WIDTH-1:0] pd_sync_ff;
  logic [`DENSITY_WIDTH-1:0] density_ff, nxt_density_ff;

  // Density pins are static; a change counts once two late stages agree.
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pd_sync_ff <= '0;
    end
    else
    begin
      pd_sync_ff <= {pd_sync_ff[2*`DENSITY_WIDTH-1:0], density_id_pins};
    end
  end

  always_comb
  begin
    nxt_density_ff = density_ff;
    if (pd_sync_ff[2*`DENSITY_WIDTH-1:`DENSITY_WIDTH] ==
        pd_sync_ff[3*`DENSITY_WIDTH-1:2*`DENSITY_WIDTH])
    begin
      nxt_density_ff = pd_sync_ff[3*`DENSITY_WIDTH-1:2*`DENSITY_WIDTH];
    end
  end

  always_comb
  begin
    nxt_state_ff = state_ff;
    nxt_cnt_ff = cnt_ff;
    nxt_req_ready_ff = 1'b0;
    nxt_rsp_valid_ff = 1'b0;
    nxt_rdata_ff = rdata_ff;
    nxt_addr_ff = addr_ff;
    nxt_sel_n_ff = sel_n_ff;
    nxt_lanes_ff = lanes_ff;
    nxt_we_n_ff = we_n_ff;
    nxt_oe_n_ff = oe_n_ff;
    nxt_wdata_ff = wdata_ff;
    nxt_drive_ff = drive_ff;
    case (state_ff)
      sram_ctrl_pkg::st_idle:
      begin
        nxt_req_ready_ff = 1'b1;
        if (req_valid && req_ready_ff)
        begin
          nxt_req_ready_ff = 1'b0;
          // Address moves only while selects and strobe are high.
          nxt_addr_ff = req_addr;
          nxt_lanes_ff = req_lanes;
          nxt_wdata_ff = req_wdata;
          if (req_write)
          begin
            nxt_state_ff = sram_ctrl_pkg::st_wr_setup;
          end
          else
          begin
            nxt_state_ff = sram_ctrl_pkg::st_rd_setup;
          end
        end
      end
      sram_ctrl_pkg::st_rd_setup:
      begin
        nxt_sel_n_ff = ~lanes_ff;
        nxt_oe_n_ff = 1'b0;
        nxt_cnt_ff = RD_CYC;
        nxt_state_ff = sram_ctrl_pkg::st_rd_wait;
      end
      sram_ctrl_pkg::st_rd_wait:
      begin
        nxt_cnt_ff = cnt_ff - CW'(1);
        if (cnt_ff == CW'(1))
        begin
          // Both access times have passed once the count ends.
          nxt_rdata_ff = bidir_data_lines_in;
          nxt_rsp_valid_ff = 1'b1;
          nxt_sel_n_ff = '1;
          nxt_oe_n_ff = 1'b1;
          nxt_cnt_ff = FL_CYC;
          nxt_state_ff = sram_ctrl_pkg::st_float;
        end
      end
      sram_ctrl_pkg::st_wr_setup:
      begin
        // Data drives only with output enable high, so no contention.
        nxt_drive_ff = 1'b1;
        nxt_sel_n_ff = ~lanes_ff;
        nxt_we_n_ff = 1'b0;
        nxt_cnt_ff = WR_CYC;
        nxt_state_ff = sram_ctrl_pkg::st_wr_pulse;
      end
      sram_ctrl_pkg::st_wr_pulse:
      begin
        nxt_cnt_ff = cnt_ff - CW'(1);
        if (cnt_ff == CW'(1))
        begin
          // Address, select and data held over the full pulse.
          nxt_we_n_ff = 1'b1;
          nxt_state_ff = sram_ctrl_pkg::st_wr_hold;
        end
      end
      sram_ctrl_pkg::st_wr_hold:
      begin
        nxt_sel_n_ff = '1;
        nxt_drive_ff = 1'b0;
        nxt_rsp_valid_ff = 1'b1;
        nxt_cnt_ff = FL_CYC;
        nxt_state_ff = sram_ctrl_pkg::st_float;
      end
      sram_ctrl_pkg::st_float:
      begin
        // Wait for the memory to float before the next cycle.
        nxt_cnt_ff = cnt_ff - CW'(1);
        if (cnt_ff == CW'(1))
        begin
          nxt_req_ready_ff = 1'b1;
          nxt_state_ff = sram_ctrl_pkg::st_idle;
        end
      end
      default:
      begin
        nxt_state_ff = sram_ctrl_pkg::st_idle;
        nxt_sel_n_ff = '1;
        nxt_we_n_ff = 1'b1;
        nxt_oe_n_ff = 1'b1;
        nxt_drive_ff = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_ff <= sram_ctrl_pkg::st_idle;
      cnt_ff <= '0;
      req_ready_ff <= 1'b0;
      rsp_valid_ff <= 1'b0;
      rdata_ff <= '0;
      addr_ff <= '0;
      sel_n_ff <= '1;
      lanes_ff <= '0;
      we_n_ff <= 1'b1;
      oe_n_ff <= 1'b1;
      wdata_ff <= '0;
      drive_ff <= 1'b0;
      density_ff <= '0;
    end
    else
    begin
      state_ff <= nxt_state_ff;
      cnt_ff <= nxt_cnt_ff;
      req_ready_ff <= nxt_req_ready_ff;
      rsp_valid_ff <= nxt_rsp_valid_ff;
      rdata_ff <= nxt_rdata_ff;
      addr_ff <= nxt_addr_ff;
      sel_n_ff <= nxt_sel_n_ff;
      lanes_ff <= nxt_lanes_ff;
      we_n_ff <= nxt_we_n_ff;
      oe_n_ff <= nxt_oe_n_ff;
      wdata_ff <= nxt_wdata_ff;
      drive_ff <= nxt_drive_ff;
      density_ff <= nxt_density_ff;
    end
  end

  assign req_ready = req_ready_ff;
  assign rsp_valid = rsp_valid_ff;
  assign rsp_rdata = rdata_ff;
  assign density_id = density_ff;
  assign word_address_lines = addr_ff;
  assign byte_lane_select_n = sel_n_ff;
  assign write_strobe_n = we_n_ff;
  assign output_enable_n = oe_n_ff;
  assign bidir_data_lines_out = wdata_ff;
  assign bidir_data_lines_oe = drive_ff;
endmodule
`default_nettype wire

// ==== sram_ctrl_chk.sv ====
`timescale 1ns/100ps
`default_nettype none
module sram_ctrl_chk (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic [19:0] word_address_lines,
  input wire logic [3:0] byte_lane_select_n,
  input wire logic write_strobe_n,
  input wire logic output_enable_n,
  input wire logic [31:0] bidir_data_lines_out,
  input wire logic bidir_data_lines_oe
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  sequence s_wr_end;
    $rose(write_strobe_n);
  endsequence
  property p_addr_quiet;
    !$stable(word_address_lines) |-> &byte_lane_select_n || write_strobe_n;
  endproperty
  a_addr_quiet: assert property (p_addr_quiet)
    else $error("address moved during an active write");
  property p_addr_first;
    $fell(write_strobe_n) |-> $stable(word_address_lines);
  endproperty
  a_addr_first: assert property (p_addr_first)
    else $error("address changed with the strobe fall");
  property p_no_fight;
    !output_enable_n && !(&byte_lane_select_n) |-> !bidir_data_lines_oe;
  endproperty
  a_no_fight: assert property (p_no_fight)
    else $error("controller drove data during a read");
  property p_addr_hold;
    s_wr_end |-> $past(word_address_lines) == $past(word_address_lines, 2)
      && $past(byte_lane_select_n) == $past(byte_lane_select_n, 2);
  endproperty
  a_addr_hold: assert property (p_addr_hold)
    else $error("address or select too short before write end");
  property p_data_hold;
    s_wr_end |-> $past(bidir_data_lines_oe) && $past(bidir_data_lines_oe, 2)
      && $past(bidir_data_lines_out) == $past(bidir_data_lines_out, 2);
  endproperty
  a_data_hold: assert property (p_data_hold)
    else $error("write data too short before write end");
endmodule
bind sram_ctrl sram_ctrl_chk u_sram_ctrl_chk (
  .clock(clock),
  .rst_b(rst_b),
  .word_address_lines(word_address_lines),
  .byte_lane_select_n(byte_lane_select_n),
  .write_strobe_n(write_strobe_n),
  .output_enable_n(output_enable_n),
  .bidir_data_lines_out(bidir_data_lines_out),
  .bidir_data_lines_oe(bidir_data_lines_oe)
);
`default_nettype wire

// ==== sram_ctrl_consts.svh ====
`ifndef SRAM_CTRL_CONSTS_SVH
`define SRAM_CTRL_CONSTS_SVH

`define CLK_PERIOD_NS 10
`define ADDR_WIDTH 20
`define DATA_WIDTH 32
`define LANES 4
`define DENSITY_WIDTH 4
// Timings of the slowest grade, in ns.
`define CYCLE_TIME_NS 25
`define SELECT_ACCESS_TIME_NS 25
`define OUTPUT_ENABLE_ACCESS_TIME_NS 12
`define ADDRESS_TO_WRITE_END_TIME_NS 15
`define WRITE_PULSE_NS 15
`define DATA_TO_WRITE_END_TIME_NS 12
`define DESELECT_FLOAT_TIME_NS 10
// Least times round up to whole cycles.
`define CEIL_CYC(t) (((t) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define READ_WAIT_CYC `CEIL_CYC(`SELECT_ACCESS_TIME_NS)
`define WRITE_WAIT_CYC `CEIL_CYC(`WRITE_PULSE_NS)
`define FLOAT_WAIT_CYC `CEIL_CYC(`DESELECT_FLOAT_TIME_NS)

`endif

// ==== sram_ctrl_pkg.sv ====
package sram_ctrl_pkg;
  typedef enum logic [2:0] {
    st_idle,
    st_rd_setup,
    st_rd_wait,
    st_wr_setup,
    st_wr_pulse,
    st_wr_hold,
    st_float
  } state_t;
endpackage

// ==== sram_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module sram_model #(
  parameter logic [3:0] DENS = 4'h5
) (
  input wire logic [19:0] addr,
  input wire logic [3:0] sel_n,
  input wire logic we_n,
  input wire logic oe_n,
  input wire logic [31:0] din,
  input var int acc_ns,
  output logic [31:0] q,
  output logic [3:0] dens
);
  logic [31:0] mem [0:1048575];
  logic [3:0] drv;
  logic [3:0] drv_d;
  logic [31:0] q_now;
  localparam int HOLD_NS = 3;
  assign dens = DENS;
  always @(posedge we_n)
    for (int i = 0; i < 4; i++)
      if (!sel_n[i]) mem[addr][8*i+:8] <= din[8*i+:8];
  always_comb drv = ~sel_n & {4{~oe_n & we_n}};
  always @(drv) drv_d <= #(acc_ns) drv;
  // Released lanes show the inverse of the stored byte, never a stale match.
  always @*
    for (int i = 0; i < 4; i++)
      q_now[8*i+:8] = drv[i] && drv_d[i] ? mem[addr][8*i+:8] :
        ~mem[addr][8*i+:8];
  // Pins keep the old word for a short hold after any change.
  always @(q_now) q <= #(HOLD_NS) q_now;
endmodule
`default_nettype wire
